/* File: cife_unit.sv */
// cife_unit: interrupt flag and enable logic with one request to the core.
// assumes: peripheral event pulses are on i_mclk; the monitored port and
// the external interrupt pin come from pins and are synchronised here.
// register layout, 8 bits each, selected by i_addr
//   0 core control: enables in bits 7..3, sticky flags in bits 2..0
//   1 peripheral enable: bits 6,2,1,0 store, the rest read zero
//   2 peripheral flags: same layout as the enables; events only set
//   3 unmapped: reads zero, writes are dropped
//
// timing seen from the register port
//   a write lands on its strobe edge and a read one cycle later shows it
//   an event pulse sets its flag on the next edge; o_irq follows one later
//   pin changes pass two sync flops and an edge stage before the flag
//   pins are not edge-checked until three edges after reset release
//
// limitations
//   a software clear in the cycle of an event leaves the flag set, so a
//   handler that clears and returns may see the request again at once
//   the ext_pin_edge event bit is not used; the pin itself sets that flag
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module cife_unit #(
    parameter int PORT_W = 4
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst,
    input  wire logic [cife_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [cife_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [cife_pkg::DATA_W-1:0] o_rdata,
    input  wire cife_pkg::cife_events_s      i_events,
    input  wire cife_pkg::cife_ccp_mode_e    i_ccp_mode,
    input  wire logic                        i_ext_irq_pin,
    input  wire logic                        i_ext_rising,
    input  wire logic [PORT_W-1:0]           i_monitored_port,
    input  wire logic [PORT_W-1:0]           i_per_pin_change_enables,
    output logic                             o_irq
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second stage
    logic [PORT_W-1:0] port_s1_q;
    logic [PORT_W-1:0] port_s2_q;
    logic [PORT_W-1:0] port_last_q;
    logic              ext_s1_q;
    logic              ext_s2_q;
    logic              ext_last_q;
    logic              prime_a_q;
    logic              prime_b_q;
    logic              prime_c_q;

    // monitored port: two sync flops, then the previous-sample stage
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            port_s1_q   <= '0;
            port_s2_q   <= '0;
            port_last_q <= '0;
        end else begin
            port_s1_q   <= i_monitored_port;
            port_s2_q   <= port_s1_q;
            port_last_q <= port_s2_q;
        end
    end

    // external pin: same chain as the port
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ext_s1_q   <= 1'b0;
            ext_s2_q   <= 1'b0;
            ext_last_q <= 1'b0;
        end else begin
            ext_s1_q   <= i_ext_irq_pin;
            ext_s2_q   <= ext_s1_q;
            ext_last_q <= ext_s2_q;
        end
    end

    // arming chain as deep as the pin chain: a pin held high through reset
    // would otherwise look like an edge while the last stage is still zero
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            prime_a_q <= 1'b0;
            prime_b_q <= 1'b0;
            prime_c_q <= 1'b0;
        end else begin
            prime_a_q <= 1'b1;
            prime_b_q <= prime_a_q;
            prime_c_q <= prime_b_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event detection; edges ignored until the sync chain has real data
    logic [PORT_W-1:0] pin_changed;
    logic              pin_change_evt;
    logic              ext_evt;

    // per-pin change enables pick which pins count
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++) begin : g_pin
            assign pin_changed[g] = (port_s2_q[g] ^ port_last_q[g])
                                    & i_per_pin_change_enables[g];
        end
    endgenerate

    assign pin_change_evt = prime_c_q & (|pin_changed);
    assign ext_evt        = prime_c_q & (i_ext_rising ? (ext_s2_q & ~ext_last_q)
                                                          : (~ext_s2_q & ext_last_q));

    ////////////////////////////////////////////////////////////////////
    // write decode
    logic wr_core;
    logic wr_pen;
    logic wr_pflg;

    assign wr_core = i_wr & (i_addr == cife_pkg::ADDR_CORE_CTRL);
    assign wr_pen  = i_wr & (i_addr == cife_pkg::ADDR_PERIPH_EN);
    assign wr_pflg = i_wr & (i_addr == cife_pkg::ADDR_PERIPH_FLG);

    ////////////////////////////////////////////////////////////////////
    // core control register: enables plus three sticky flags
    logic [cife_pkg::DATA_W-1:0] core_q;
    logic [cife_pkg::DATA_W-1:0] core_d;

    always_comb begin
        core_d = core_q;
        if (wr_core) begin
            core_d = i_wdata;
        end
        // hardware set after the write so a same-cycle set wins
        if (i_events.timer8_overflow) begin
            core_d[cife_pkg::BIT_T8IF] = 1'b1;
        end
        if (ext_evt) begin
            core_d[cife_pkg::BIT_EXTIF] = 1'b1;
        end
        if (pin_change_evt) begin
            core_d[cife_pkg::BIT_PCIF] = 1'b1;
        end
    end

    // pin-change flag bit is undefined at reset; zero chosen. the 8-bit
    // timer count lives outside this unit so reset never touches it
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            core_q <= cife_pkg::CORE_RESET;
        end else begin
            core_q <= core_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // peripheral enable register: only implemented bits store
    logic [cife_pkg::DATA_W-1:0] pen_q;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pen_q <= cife_pkg::PERIPH_RESET;
        end else if (wr_pen) begin
            pen_q <= i_wdata & cife_pkg::PERIPH_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // peripheral flag register: sticky, set beats clear
    logic [cife_pkg::DATA_W-1:0] pflg_q;
    logic [cife_pkg::DATA_W-1:0] pflg_d;
    logic [cife_pkg::DATA_W-1:0] pflg_set;
    logic                        ccp_evt;

    // pwm mode never raises the capture/compare flag
    always_comb begin
        case (i_ccp_mode)
            cife_pkg::CIFE_CCP_CAPTURE: ccp_evt = i_events.capture_event;
            cife_pkg::CIFE_CCP_COMPARE: ccp_evt = i_events.compare_match;
            cife_pkg::CIFE_CCP_PWM:     ccp_evt = 1'b0;
            default:                    ccp_evt = 1'b0;
        endcase
    end

    always_comb begin
        pflg_set = cife_pkg::ZERO_BYTE;
        pflg_set[cife_pkg::BIT_CONV] = i_events.conversion_done;
        pflg_set[cife_pkg::BIT_CCMP] = ccp_evt;
        pflg_set[cife_pkg::BIT_PMAT] = i_events.period_match;
        pflg_set[cife_pkg::BIT_T16]  = i_events.timer16_overflow;
        pflg_d = pflg_q;
        if (wr_pflg) begin
            pflg_d = i_wdata & cife_pkg::PERIPH_MASK;
        end
        pflg_d = pflg_d | pflg_set;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pflg_q <= cife_pkg::PERIPH_RESET;
        end else begin
            pflg_q <= pflg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request combine
    logic core_term;
    logic periph_term;

    assign core_term =
        (core_q[cife_pkg::BIT_T8IE]  & core_q[cife_pkg::BIT_T8IF])
      | (core_q[cife_pkg::BIT_EXTIE] & core_q[cife_pkg::BIT_EXTIF])
      | (core_q[cife_pkg::BIT_PCIE]  & core_q[cife_pkg::BIT_PCIF]);

    // enable bits 6,2,1,0 line up with flag bits
    assign periph_term = core_q[cife_pkg::BIT_PGE] & (|(pen_q & pflg_q));

    // registered so the core sees a clean level
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= core_q[cife_pkg::BIT_GIE] & (core_term | periph_term);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, one cycle after the read strobe, zero otherwise
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= cife_pkg::ZERO_BYTE;
        end else if (i_rd) begin
            case (i_addr)
                cife_pkg::ADDR_CORE_CTRL:  o_rdata <= core_q;
                cife_pkg::ADDR_PERIPH_EN:  o_rdata <= pen_q;
                cife_pkg::ADDR_PERIPH_FLG: o_rdata <= pflg_q;
                default:                   o_rdata <= cife_pkg::ZERO_BYTE;
            endcase
        end else begin
            o_rdata <= cife_pkg::ZERO_BYTE;
        end
    end

endmodule : cife_unit

`default_nettype wire

/* File: cife_pkg.sv */
// cife_pkg: register indices, bit positions, reset values and types
// for the core interrupt flag and enable unit.
// assumes: 8-bit register port driven by the processor core.
package cife_pkg;

    // register indices on the plain register port
    localparam logic [1:0] ADDR_CORE_CTRL  = 2'h0;
    localparam logic [1:0] ADDR_PERIPH_EN  = 2'h1;
    localparam logic [1:0] ADDR_PERIPH_FLG = 2'h2;
    localparam int         ADDR_W          = 2;
    localparam int         DATA_W          = 8;

    // core control register bit positions
    localparam int BIT_GIE   = 7;
    localparam int BIT_PGE   = 6;
    localparam int BIT_T8IE  = 5;
    localparam int BIT_EXTIE = 4;
    localparam int BIT_PCIE  = 3;
    localparam int BIT_T8IF  = 2;
    localparam int BIT_EXTIF = 1;
    localparam int BIT_PCIF  = 0;

    // peripheral enable / flag bit positions (same layout in both)
    localparam int BIT_CONV  = 6;
    localparam int BIT_CCMP  = 2;
    localparam int BIT_PMAT  = 1;
    localparam int BIT_T16   = 0;

    // implemented-bit mask of the peripheral registers, then reset values and a zero byte
    localparam logic [7:0] PERIPH_MASK   = 8'h47;
    localparam logic [7:0] CORE_RESET    = 8'h00;
    localparam logic [7:0] PERIPH_RESET  = 8'h00;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;

    // capture/compare unit operating mode
    typedef enum logic [1:0] {
        CIFE_CCP_CAPTURE,
        CIFE_CCP_COMPARE,
        CIFE_CCP_PWM
    } cife_ccp_mode_e;

    // one-cycle event pulses from the peripherals
    typedef struct packed {
        logic timer8_overflow;
        logic ext_pin_edge;
        logic conversion_done;
        logic capture_event;
        logic compare_match;
        logic period_match;
        logic timer16_overflow;
    } cife_events_s;

endpackage : cife_pkg

/* File: cife_event_src.sv */
// cife_event_src: peripheral event sources beside the interrupt unit.
// assumes: the bench requests events on i_mclk, one cycle at a time.
`timescale 1ns/10ps
`default_nettype none
module cife_event_src (
    input  wire logic                   i_mclk,
    input  wire logic [6:0]             i_fire,
    output var  cife_pkg::cife_events_s o_events
);
    // a request becomes a one-cycle pulse after the edge, as a rollover would
    always_ff @(posedge i_mclk) begin
        o_events <= cife_pkg::cife_events_s'(i_fire);
    end
endmodule : cife_event_src
`default_nettype wire

/* File: cife_unit_asserts.sv */
// cife_unit_asserts: port-level checks of the interrupt flag unit.
// assumes: bound to cife_unit; register index 3 is unmapped.
`timescale 1ns/10ps
`default_nettype none
module cife_unit_asserts (
    input wire logic                   i_mclk,
    input wire logic                   i_rst,
    input wire logic [1:0]             i_addr,
    input wire logic [7:0]             i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [7:0]             o_rdata,
    input wire cife_pkg::cife_events_s i_events,
    input wire logic                   o_irq
);
    logic [4:0] ctl_q;
    logic [7:0] pen_q;
    wire        global_irq_enable = ctl_q[4];
    wire        pge = ctl_q[3];
    wire        core_en = |ctl_q[2:0];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // enables change only by software, so a shadow of the writes is exact
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctl_q <= 5'h00;
            pen_q <= 8'h00;
        end else if (i_wr && i_addr == cife_pkg::ADDR_CORE_CTRL) begin
            ctl_q <= i_wdata[7:3];
        end else if (i_wr && i_addr == cife_pkg::ADDR_PERIPH_EN) begin
            pen_q <= i_wdata & cife_pkg::PERIPH_MASK;
        end
    end
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read");
    unmapped_rd_a: assert property ($past(i_rd) && $past(i_addr) == 2'h3 |-> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    unimpl_zero_a: assert property ($past(i_rd) && $past(i_addr) != 2'h0 |-> !o_rdata[7] && !(|o_rdata[5:3]))
        else $error("unimplemented bit set");
    en_readback_a: assert property ($past(i_rd) && $past(i_addr) == 2'h1 |-> o_rdata == $past(pen_q))
        else $error("enable readback wrong");
    gie_block_a: assert property (!$past(global_irq_enable) |-> !o_irq)
        else $error("request without global enable");
    group_block_a: assert property (!$past(pge) && !$past(core_en) |-> !o_irq)
        else $error("peripheral request without group enable");
    t16_irq_a: assert property (i_events.timer16_overflow && global_irq_enable && pge && pen_q[0] && !i_wr |-> ##2 o_irq)
        else $error("no request after timer16 overflow");
    t8_irq_a: assert property (i_events.timer8_overflow && global_irq_enable && ctl_q[2] && !i_wr |-> ##2 o_irq)
        else $error("no request after timer8 overflow");
    irq_hold_a: assert property (o_irq && !$past(i_wr) |=> o_irq)
        else $error("request dropped without write");
    cover property (i_events.timer16_overflow ##2 o_irq);
    cover property (i_rd && i_addr == 2'h3);
    cover property ($fell(o_irq));
endmodule : cife_unit_asserts
bind cife_unit cife_unit_asserts cife_unit_asserts_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_events(i_events), .o_irq(o_irq));
`default_nettype wire

/* File: cife_unit_test.sv */
// cife_unit_test: self-checking bench for the interrupt flag unit.
// assumes: cife_event_src makes the peripheral pulses; 4 ns clock.
`timescale 1ns/10ps
`default_nettype none
module cife_unit_test;
    typedef struct packed {logic [1:0] a; logic [7:0] d; logic [7:0] e;} cife_row_s;
    logic mclk, rst, wr, rd, pin, rise, irq;
    logic [1:0] addr;
    logic [7:0] wdata, rdata;
    logic [6:0] fire_req;
    logic [3:0] port, pce;
    cife_pkg::cife_events_s ev;
    cife_pkg::cife_ccp_mode_e mode;
    int errors, checked;
    cife_row_s rows [6] = '{'{2'h0, 8'hF8, 8'hF8}, '{2'h1, 8'hFF, 8'h47}, '{2'h2, 8'hFF, 8'h47},
        '{2'h2, 8'h00, 8'h00}, '{2'h3, 8'hFF, 8'h00}, '{2'h0, 8'h00, 8'h00}};
    logic [6:0] evs [4] = '{7'h10, 7'h08, 7'h02, 7'h01};
    logic [7:0] fls [4] = '{8'h40, 8'h04, 8'h02, 8'h01};
    cife_event_src cife_event_src_inst (.i_mclk(mclk), .i_fire(fire_req), .o_events(ev));
    cife_unit #(.PORT_W(4)) cife_unit_inst (.i_mclk(mclk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_events(ev), .i_ccp_mode(mode),
        .i_ext_irq_pin(pin), .i_ext_rising(rise), .i_monitored_port(port),
        .i_per_pin_change_enables(pce), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // request settles two edges after its cause; three leaves margin
    task automatic chk_irq(input logic e);
        repeat (3) @(posedge mclk);
        #1;
        checked++;
        if (irq !== e) begin
            errors++;
            $display("Error irq expected %b seen %b", e, irq);
        end
    endtask : chk_irq
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk("rdata", e, rdata);
    endtask : rd_reg
    task automatic fire(input logic [6:0] f);
        @(posedge mclk) fire_req <= f;
        @(posedge mclk) fire_req <= 7'h00;
        repeat (5) @(posedge mclk);
    endtask : fire
    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // the whole run needs some hundreds of cycles
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        print_verdict();
    end
    initial begin
        {wr, rd, pin, addr, wdata, fire_req, port, pce} = '0;
        rise = 1'b1;
        mode = cife_pkg::CIFE_CCP_CAPTURE;
        rst = 1'b1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 3; i++) rd_reg(2'(i), 8'h00);
        chk_irq(1'b0);
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rows[i].e);
        end
        $display("register rows done");
        // all event pulses fire with the core control enables off; peripheral enables still 47
        fire(7'h7F);
        rd_reg(2'h2, 8'h47);
        rd_reg(2'h0, 8'h04);
        wr_reg(2'h1, 8'h47);
        wr_reg(2'h0, 8'h80);
        chk_irq(1'b0);
        wr_reg(2'h0, 8'hC0);
        chk_irq(1'b1);
        wr_reg(2'h0, 8'h40);
        chk_irq(1'b0);
        // each peripheral source alone, stale flag cleared before enabling
        foreach (evs[i]) begin
            wr_reg(2'h2, 8'h00);
            wr_reg(2'h1, fls[i]);
            wr_reg(2'h0, 8'hC0);
            chk_irq(1'b0);
            fire(evs[i]);
            rd_reg(2'h2, fls[i]);
            chk_irq(1'b1);
        end
        @(posedge mclk) mode <= cife_pkg::CIFE_CCP_COMPARE;
        wr_reg(2'h2, 8'h00);
        fire(7'h04);
        rd_reg(2'h2, 8'h04);
        @(posedge mclk) mode <= cife_pkg::CIFE_CCP_PWM;
        wr_reg(2'h2, 8'h00);
        fire(7'h04);
        rd_reg(2'h2, 8'h00);
        $display("source test done");
        // overflow pulse meets a software clear on one edge
        @(posedge mclk) fire_req <= 7'h01;
        @(posedge mclk) fire_req <= 7'h00;
        addr <= 2'h2;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge mclk) wr <= 1'b0;
        rd_reg(2'h2, 8'h01);
        // pin change only through an enabled pin, then the external pin
        wr_reg(2'h0, 8'h00);
        @(posedge mclk) pce <= 4'h1;
        @(posedge mclk) port <= 4'h2;
        repeat (5) @(posedge mclk);
        rd_reg(2'h0, 8'h00);
        @(posedge mclk) port <= 4'h3;
        repeat (5) @(posedge mclk);
        rd_reg(2'h0, 8'h01);
        @(posedge mclk) pin <= 1'b1;
        repeat (5) @(posedge mclk);
        rd_reg(2'h0, 8'h03);
        wr_reg(2'h0, 8'h92);
        chk_irq(1'b1);
        wr_reg(2'h0, 8'hA2);
        chk_irq(1'b0);
        fire(7'h40);
        chk_irq(1'b1);
        $display("pin test done");
        // falling edge selected, then a mid-run reset with pins held high
        @(posedge mclk) rise <= 1'b0;
        wr_reg(2'h0, 8'h00);
        @(posedge mclk) pin <= 1'b0;
        repeat (5) @(posedge mclk);
        rd_reg(2'h0, 8'h02);
        @(posedge mclk) pin <= 1'b1;
        repeat (5) @(posedge mclk);
        rd_reg(2'h0, 8'h02);
        @(posedge mclk) rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        rd_reg(2'h0, 8'h00);
        rd_reg(2'h2, 8'h00);
        chk_irq(1'b0);
        $display("edge and reset test done");
        print_verdict();
    end
endmodule : cife_unit_test
`default_nettype wire
